// >>> esbc_defines.svh
`ifndef ESBC_DEFINES_SVH
`define ESBC_DEFINES_SVH
// wishbone word offsets (byte addresses)
`define ESBC_OFF_CFG_LO   8'h00
`define ESBC_OFF_CFG_HI   8'h04
`define ESBC_OFF_STATUS   8'h08
// reset value of both configuration registers
`define ESBC_CFG_RESET    32'h0000_0000
// byte-field positions
`define ESBC_BUS_CLOCK_OUTPUT_ENABLE_BIT    7
`define ESBC_SEQUENTIAL_ACCESS_ENABLE_BIT    6
`define ESBC_SEQWS_LSB    4
`define ESBC_RNDWS_LSB    2
`define ESBC_WIDTH_LSB    0
// address bits used for select decode, pcmcia area and 16-bit io bit mapping
`define ESBC_CS_LSB       28
`define ESBC_PCM_A26      26
`define ESBC_PCM_A27      27
`define ESBC_PCM_A25      25
// wait-state bases: random 4..1, page 3..0
`define ESBC_RND_BASE     3'h4
`define ESBC_SEQ_BASE     3'h3
// words per page-mode burst
`define ESBC_PAGE_WORDS   3'h4
// strobe cycles before ready is trusted: link capture plus three sync flops
`define ESBC_RDY_SETTLE   3'h4
`endif

// >>> esbc_exp_model.sv
`timescale 1ns/1ps
`default_nettype none
// far-side peripheral: holds ready low for a set number of link clocks per select
module esbc_exp_model
(
	input  wire logic        i_link_clk,
	input  wire logic [7:0]  i_chip_select_n,
	input  wire logic [27:0] i_exp_addr,
	input  wire logic [3:0]  i_stall,
	output logic             o_ready,
	output logic      [31:0] o_rdata
);
	logic [3:0]  cnt_q  = 4'h0;  // link clocks of stretch still owed
	logic [31:0] last_q = 32'h0; // last value seen on the data lines
	logic        idle;           // no select is low

	assign idle = &i_chip_select_n;

	////////////////////////////////////////////////////////////////
	// stretch counter runs on the peripheral's own timing reference
	always_ff @(posedge i_link_clk)
	begin
		if (idle)
			cnt_q <= i_stall; // reload while deselected
		else if (cnt_q != 4'h0)
			cnt_q <= cnt_q - 4'h1;
	end

	// ready has a board pull-up, so it reads high while nobody drives it
	assign o_ready = idle | (cnt_q == 4'h0);

	////////////////////////////////////////////////////////////////
	// released data lines show the inverse of the last value, never a stale copy
	always_ff @(posedge i_link_clk)
	begin
		last_q <= o_rdata;
	end
	assign o_rdata = idle ? ~last_q : {4{i_exp_addr[7:0]}};
endmodule
`default_nettype wire

// >>> esbc_link_if.sv
`timescale 1ns/1ps
`default_nettype none
// ready level caught on the link clock, handed to the system domain
interface esbc_link_if;
	logic ready_lk;
	modport link (output ready_lk);
	modport core (input ready_lk);
endinterface
`default_nettype wire

// >>> esbc_link_sampler.sv
`timescale 1ns/1ps
`default_nettype none
// samples the ready pin on the link clock, the peripheral's own reference
module esbc_link_sampler
(
	input  wire logic i_link_clk,
	input  wire logic i_exp_ready,
	esbc_link_if.link lk
);
	logic ready_q; // link-domain copy, only a data flop, no control state

	// single capture; the system side resynchronises it with three flops
	always_ff @(posedge i_link_clk)
	begin
		ready_q <= i_exp_ready;
	end

	assign lk.ready_lk = ready_q;
endmodule
`default_nettype wire

// >>> esbc_pkg.sv
package esbc_pkg;
	// effective transfer width after boot-flag and pcmcia decode
	typedef enum logic [1:0] {W32, W16, W8, WPCM} esbc_width_e;
	// access sequencer states
	typedef enum logic [1:0] {S_IDLE, S_COUNT, S_STROBE, S_FINISH} esbc_fsm_e;
	// whole state of the top module
	typedef struct packed {
		esbc_fsm_e   fsm;
		logic [31:0] cfg_lo;
		logic [31:0] cfg_hi;
		logic        boot8;
		logic [2:0]  pe_s;
		logic [2:0]  rdy_s;
		logic        rdy;
		logic        wb_ack;
		logic [31:0] wb_dat;
		logic [2:0]  cs;
		logic [7:0]  cs_n;
		logic [2:0]  wcnt;
		logic [1:0]  beat;
		logic [1:0]  left;
		logic        io16;
		esbc_width_e mode;
		logic        page_on;
		logic [2:0]  page_cnt;
		logic        pg;
		logic [27:0] addr;
		logic [27:0] ea;
		logic [31:0] rdata;
		logic        done;
		logic        clk;
	} esbc_state_s;
endpackage

// >>> esbc_top.sv
// Operation
// (R01) two 32-bit registers, four byte fields each
// (R02) field: bus_clock_output_enable, seq enable, seq ws, rnd ws, width
// (R03) system reset clears both configuration registers
// (R04) narrow boot flag follows port pin at power-on
// (R05) flag clear: 32, 16, 8, pcmcia
// (R06) flag set: 8, pcmcia, 32, 16
// (R07) pcmcia width and area from a26/a27
// (R08) split word access into narrow beats
// (R09) 16-bit io: no split, a25 onto bit 1
// (R10) 16-bit io forces expansion address bit 25 low
// (R11) random wait states 4,3,2,1
// (R12) page wait states 3,2,1,0
// (R13) quad-aligned sequential bursts use page timing
// (R14) page bursts end after four words
// (R15) clock output runs during clock-enabled accesses
// (R16) ready input stretches the access
// (R17) back-to-back accesses keep clock running
// (R18) decoded select's byte sets each access timing
`timescale 1ns/1ps
`default_nettype none
`include "esbc_defines.svh"
module esbc_top
(
	input  wire logic        i_clk,
	input  wire logic        i_reset_n,
	input  wire logic        i_power_on_reset,
	input  wire logic        i_port_e0,
	input  wire logic        i_link_clk,
	input  wire logic [7:0]  i_wb_adr,
	input  wire logic [31:0] i_wb_dat,
	input  wire logic [3:0]  i_wb_sel,
	input  wire logic        i_wb_we,
	input  wire logic        i_wb_cyc,
	input  wire logic        i_wb_stb,
	output logic      [31:0] o_wb_dat,
	output logic             o_wb_ack,
	input  wire logic        i_acc_valid,
	input  wire logic [30:0] i_acc_addr,
	input  wire logic        i_acc_word,
	input  wire logic        i_acc_seq,
	output logic             o_acc_done,
	output logic      [31:0] o_acc_rdata,
	output logic      [7:0]  o_chip_select_n,
	output logic      [27:0] o_exp_addr,
	output logic      [1:0]  o_exp_width,
	output logic             o_expansion_clock_out,
	input  wire logic        i_expansion_ready_in,
	input  wire logic [31:0] i_exp_rdata
);
	////////////////////////////////////////////////////////////////////////////////
	esbc_pkg::esbc_state_s q; // registered state
	esbc_pkg::esbc_state_s n; // next state
	esbc_link_if           lk (); // carrier from the link sampler

	// link-domain capture of the ready pin
	esbc_link_sampler u_link
	(
		.i_link_clk  (i_link_clk),
		.i_exp_ready (i_expansion_ready_in),
		.lk          (lk)
	);

	////////////////////////////////////////////////////////////////////////////////
	// configuration byte of a select; low register serves 0..3
	function automatic logic [7:0] cfg_byte(input logic [31:0] lo, input logic [31:0] hi,
		input logic [2:0] cs);
		logic [31:0] r;
		r = cs[2] ? hi : lo;
		cfg_byte = r[cs[1:0]*8 +: 8];
	endfunction

	// width code meaning depends on the boot flag
	function automatic esbc_pkg::esbc_width_e width_of(input logic [1:0] c, input logic b8);
		logic [1:0] k;
		k = c;
		if (b8)
			k = c + 2'h2; // R06
		case (k) // R05
			2'h0:    width_of = esbc_pkg::W32;
			2'h1:    width_of = esbc_pkg::W16;
			2'h2:    width_of = esbc_pkg::W8;
			default: width_of = esbc_pkg::WPCM;
		endcase
	endfunction

	// expansion address of one beat
	function automatic logic [27:0] beat_addr(input logic [27:0] a, input logic [1:0] bt,
		input esbc_pkg::esbc_width_e m, input logic io);
		logic [27:0] r;
		r = a;
		if (io)
		begin
			r[1]                = a[`ESBC_PCM_A25]; // R09
			r[`ESBC_PCM_A25]    = 1'b0; // R10
		end
		else if (m == esbc_pkg::W8)
			r[1:0] = bt;
		else if (m == esbc_pkg::W16)
			r[1:0] = {bt[0], 1'b0};
		beat_addr = r;
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	logic [7:0]              sb;    // byte of the selected chip
	logic [2:0]              ncs;   // select decoded from request
	esbc_pkg::esbc_width_e   wm;    // effective width of request
	logic                    nio;   // request is 16-bit pcmcia io
	logic                    pgt;   // request takes page timing
	logic                    wbreq; // new wishbone request
	logic [7:0]              sbc;   // byte of the select in flight

	// next-state logic for bus slave, sequencer and synchronisers
	always_comb
	begin
		n      = q;
		n.done = 1'b0;
		n.wb_ack = 1'b0;
		ncs    = i_acc_addr[`ESBC_CS_LSB +: 3];
		sb     = cfg_byte(q.cfg_lo, q.cfg_hi, ncs); // R18
		sbc    = cfg_byte(q.cfg_lo, q.cfg_hi, q.cs);
		wm     = width_of(sb[`ESBC_WIDTH_LSB +: 2], q.boot8); // R02
		nio    = 1'b0;
		pgt    = 1'b0;
		wbreq  = i_wb_cyc && i_wb_stb && !q.wb_ack;
		// three-flop synchronisers; a change counts when the last two agree
		n.rdy_s = {q.rdy_s[1:0], lk.ready_lk};
		n.pe_s  = {q.pe_s[1:0], i_port_e0};
		if (q.rdy_s[2] == q.rdy_s[1])
			n.rdy = q.rdy_s[2];
		// boot flag tracks the strap only while power-on reset is held
		if (i_power_on_reset && (q.pe_s[2] == q.pe_s[1]))
			n.boot8 = q.pe_s[2]; // R04
		// pcmcia area decode
		if (wm == esbc_pkg::WPCM)
		begin
			case ({i_acc_addr[`ESBC_PCM_A27], i_acc_addr[`ESBC_PCM_A26]}) // R07
				2'b00:   wm = esbc_pkg::W8;
				2'b01:   wm = esbc_pkg::W16;
				2'b10:   wm = esbc_pkg::W8;
				default:
				begin
					wm  = esbc_pkg::W16;
					nio = 1'b1;
				end
			endcase
		end
		// page timing only inside a live quad-aligned burst of the same select
		if (sb[`ESBC_SEQUENTIAL_ACCESS_ENABLE_BIT] && i_acc_seq && q.page_on && (ncs == q.cs)
			&& (q.page_cnt < `ESBC_PAGE_WORDS))
			pgt = 1'b1; // R13

		// wishbone slave: one-cycle registered ack, unmapped reads zero
		if (wbreq)
		begin
			n.wb_ack = 1'b1;
			n.wb_dat = 32'h0000_0000;
			case (i_wb_adr)
				`ESBC_OFF_CFG_LO: n.wb_dat = q.cfg_lo; // R01
				`ESBC_OFF_CFG_HI: n.wb_dat = q.cfg_hi;
				`ESBC_OFF_STATUS: n.wb_dat = {26'h0, q.page_cnt, q.page_on,
					(q.fsm != esbc_pkg::S_IDLE), q.boot8};
				default:          n.wb_dat = 32'h0000_0000;
			endcase
			if (i_wb_we)
			begin
				for (int i = 0; i < 4; i++)
				begin
					if (i_wb_sel[i] && (i_wb_adr == `ESBC_OFF_CFG_LO))
						n.cfg_lo[i*8 +: 8] = i_wb_dat[i*8 +: 8];
					if (i_wb_sel[i] && (i_wb_adr == `ESBC_OFF_CFG_HI))
						n.cfg_hi[i*8 +: 8] = i_wb_dat[i*8 +: 8];
				end
			end
		end

		// access sequencer
		case (q.fsm)
			esbc_pkg::S_IDLE, esbc_pkg::S_FINISH:
			begin
				n.fsm  = esbc_pkg::S_IDLE;
				n.cs_n = 8'hff;
				if (i_acc_valid)
				begin
					n.fsm  = esbc_pkg::S_COUNT;
					n.cs   = ncs;
					n.cs_n = ~(8'h01 << ncs);
					n.addr = i_acc_addr[27:0];
					n.mode = wm;
					n.io16 = nio;
					n.pg   = pgt;
					n.rdata = 32'h0000_0000;
					// wait states in system clocks
					n.wcnt = pgt ? (`ESBC_SEQ_BASE - {1'b0, sb[`ESBC_SEQWS_LSB +: 2]}) // R12
						: (`ESBC_RND_BASE - {1'b0, sb[`ESBC_RNDWS_LSB +: 2]}); // R11
					// word split into beats unless 16-bit io
					n.beat = 2'h0;
					n.left = 2'h0;
					if (i_acc_word && !nio)
					begin
						if (wm == esbc_pkg::W16)
							n.left = 2'h1; // R08
						else if (wm == esbc_pkg::W8)
							n.left = 2'h3; // R08
					end
					else if (!i_acc_word)
						n.beat = (wm == esbc_pkg::W16) ? {1'b0, i_acc_addr[1]} : i_acc_addr[1:0];
					n.ea = beat_addr(i_acc_addr[27:0], n.beat, wm, nio);
					// burst bookkeeping; fourth word ends the page
					if (pgt)
						n.page_cnt = q.page_cnt + 3'h1;
					else
					begin
						n.page_on  = sb[`ESBC_SEQUENTIAL_ACCESS_ENABLE_BIT] && (i_acc_addr[3:2] == 2'h0);
						n.page_cnt = 3'h1;
					end
					if (n.page_cnt >= `ESBC_PAGE_WORDS)
						n.page_on = 1'b0; // R14
				end
			end
			esbc_pkg::S_COUNT:
			begin
				if (q.wcnt == 3'h0)
				begin
					// let the synchronised ready catch up with the new select
					n.fsm  = esbc_pkg::S_STROBE;
					n.wcnt = `ESBC_RDY_SETTLE;
				end
				else
					n.wcnt = q.wcnt - 3'h1;
			end
			esbc_pkg::S_STROBE:
			begin
				// settle first, so a stale high ready cannot end the beat early;
				// then held here while the peripheral keeps ready low
				if (q.wcnt != 3'h0)
					n.wcnt = q.wcnt - 3'h1;
				else if (q.rdy) // R16
				begin
					case (q.mode)
						esbc_pkg::W8:  n.rdata[q.beat*8 +: 8] = i_exp_rdata[7:0];
						esbc_pkg::W16: n.rdata[q.beat[0]*16 +: 16] = i_exp_rdata[15:0];
						default:       n.rdata = i_exp_rdata;
					endcase
					if (q.io16)
						n.rdata[31:16] = 16'h0000; // R09
					if (q.left == 2'h0)
					begin
						n.fsm  = esbc_pkg::S_FINISH;
						n.done = 1'b1;
						n.cs_n = 8'hff;
					end
					else
					begin
						n.fsm  = esbc_pkg::S_COUNT;
						n.beat = q.beat + 2'h1;
						n.left = q.left - 2'h1;
						n.ea   = beat_addr(q.addr, n.beat, q.mode, q.io16);
						n.wcnt = q.pg ? (`ESBC_SEQ_BASE - {1'b0, sbc[`ESBC_SEQWS_LSB +: 2]})
							: (`ESBC_RND_BASE - {1'b0, sbc[`ESBC_RNDWS_LSB +: 2]});
					end
				end
			end
			default: n.fsm = esbc_pkg::S_IDLE;
		endcase

		// clock runs through an access and its finish cycle so that a
		// following request to a clocked select sees no gap
		if (((q.fsm != esbc_pkg::S_IDLE) && sbc[`ESBC_BUS_CLOCK_OUTPUT_ENABLE_BIT]) // R15
			|| (i_acc_valid && sb[`ESBC_BUS_CLOCK_OUTPUT_ENABLE_BIT] && (q.fsm == esbc_pkg::S_FINISH
			|| q.fsm == esbc_pkg::S_IDLE))) // R17
			n.clk = !q.clk;
		else
			n.clk = 1'b0;
	end

	////////////////////////////////////////////////////////////////////////////////
	// one register for the whole state; boot flag survives system reset
	always_ff @(posedge i_clk)
	begin
		if (!i_reset_n)
		begin
			q        <= '0; // R03
			q.fsm    <= esbc_pkg::S_IDLE;
			q.cs_n   <= 8'hff;
			q.cfg_lo <= `ESBC_CFG_RESET;
			q.cfg_hi <= `ESBC_CFG_RESET;
			q.boot8  <= n.boot8;
			q.pe_s   <= n.pe_s;
		end
		else
			q <= n;
	end

	// outputs straight from the state register
	assign o_wb_ack              = q.wb_ack;
	assign o_wb_dat              = q.wb_dat;
	assign o_acc_done            = q.done;
	assign o_acc_rdata           = q.rdata;
	assign o_chip_select_n       = q.cs_n;
	assign o_exp_addr            = q.ea;
	assign o_exp_width           = q.mode;
	assign o_expansion_clock_out = q.clk;

	////////////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_reset_n);

	wb_ack_pulse_a: assert property (o_wb_ack |=> !o_wb_ack) // R01
		else $error("ack held two cycles");
	cfg_cleared_a: assert property (@(posedge i_clk) $rose(i_reset_n) |-> (q.cfg_lo == 32'h0)
		&& (q.cfg_hi == 32'h0)) // R03
		else $error("config not cleared by reset");
	io16_bit25_a: assert property (q.io16 && q.fsm != esbc_pkg::S_IDLE |-> !o_exp_addr[25]) // R10
		else $error("bit 25 driven in 16-bit io");
	io16_bit1_a: assert property (q.io16 && q.fsm == esbc_pkg::S_STROBE
		|-> o_exp_addr[1] == q.addr[25]) // R09
		else $error("bit 1 not from a25");
	page_limit_a: assert property ((q.page_cnt <= 3'h4) && !((q.page_cnt == 3'h4) && q.page_on)) // R14
		else $error("page burst over four words");
	rnd_wait_a: assert property ($rose(q.fsm == esbc_pkg::S_COUNT) && !q.pg && q.beat == 2'h0
		&& sbc[3:2] == 2'h0 |-> q.wcnt == 3'h4) // R11
		else $error("random wait count wrong");
	ready_stall_a: assert property (q.fsm == esbc_pkg::S_STROBE && !q.rdy
		|=> q.fsm == esbc_pkg::S_STROBE && !o_acc_done) // R16
		else $error("access ended without ready");
	clk_off_a: assert property (q.fsm == esbc_pkg::S_COUNT && !sbc[7]
		|=> !o_expansion_clock_out) // R15
		else $error("clock runs on unclocked select");
	clk_run_a: assert property (q.fsm == esbc_pkg::S_COUNT && sbc[7] && $stable(q.cs)
		&& $past(q.fsm) == esbc_pkg::S_COUNT |-> o_expansion_clock_out != $past(o_expansion_clock_out)) // R15
		else $error("clock stopped during access");
endmodule
`default_nettype wire

// >>> test_expansion_select_bus_config.sv
`timescale 1ns/1ps
`default_nettype none
module test_expansion_select_bus_config;
	logic        i_clk = 1'b0;   // system clock
	logic        lclk = 1'b0;    // link clock
	logic        rst_n = 1'b0;   // system reset
	logic        por = 1'b1;     // power-on indicator
	logic        pe0 = 1'b0;     // boot strap pin
	logic [7:0]  adr = 8'h00;
	logic [31:0] wdat = 32'h0;
	logic        we = 1'b0;
	logic        cyc = 1'b0;
	logic        stb = 1'b0;
	logic        acc_req = 1'b0;
	logic [30:0] acc_addr = 31'h0;
	logic        acc_word = 1'b0;
	logic        acc_seq = 1'b0;
	logic [3:0]  stall = 4'h0;   // stretch asked of the peripheral
	logic [31:0] rdat, ardata, erdata;
	logic        ack, done, eclk, ready, acc_valid;
	logic [7:0]  csn;
	logic [27:0] eaddr, last_a;
	logic [1:0]  ewidth, w_seen;
	logic        a25;            // expansion bit 25 ever high in an access
	int          lat, beats, tog, cs_bad, n_errors, samples_checked;
	logic [1:0]  tbl [2][4] = '{'{2'h0, 2'h1, 2'h2, 2'h1}, '{2'h2, 2'h1, 2'h0, 2'h1}};

	always #25 i_clk = ~i_clk;
	initial
	begin
		#7;
		forever #32 lclk = ~lclk; // unrelated phase
	end
	// valid falls in the done cycle so finish never takes a stale request
	assign acc_valid = acc_req & ~done;

	esbc_top dut_u (.i_clk(i_clk), .i_reset_n(rst_n), .i_power_on_reset(por), .i_port_e0(pe0),
		.i_link_clk(lclk), .i_wb_adr(adr), .i_wb_dat(wdat), .i_wb_sel(4'hf), .i_wb_we(we),
		.i_wb_cyc(cyc), .i_wb_stb(stb), .o_wb_dat(rdat), .o_wb_ack(ack),
		.i_acc_valid(acc_valid), .i_acc_addr(acc_addr), .i_acc_word(acc_word),
		.i_acc_seq(acc_seq), .o_acc_done(done), .o_acc_rdata(ardata),
		.o_chip_select_n(csn), .o_exp_addr(eaddr), .o_exp_width(ewidth),
		.o_expansion_clock_out(eclk), .i_expansion_ready_in(ready), .i_exp_rdata(erdata));
	esbc_exp_model peer_u (.i_link_clk(lclk), .i_chip_select_n(csn), .i_exp_addr(eaddr),
		.i_stall(stall), .o_ready(ready), .o_rdata(erdata));

	////////////////////////////////////////////////////////////////
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		samples_checked++;
		if (got !== exp)
		begin
			n_errors++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic finish_test;
		$display("checks %0d errors %0d", samples_checked, n_errors);
		if (n_errors == 0 && samples_checked > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	// classic single wishbone cycle; waits on ack, never assumes its timing
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] r);
		int n;
		n = 0;
		@(posedge i_clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		do
		begin
			@(posedge i_clk);
			n++;
		end
		while (ack !== 1'b1 && n < 50);
		r = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
		if (n >= 50)
		begin
			n_errors++;
			finish_test();
		end
	endtask

	// one select's byte in place, the other three bytes zero
	task automatic setcfg(input int s, input logic [7:0] b);
		logic [31:0] r;
		wb(1'b1, (s < 4) ? 8'h00 : 8'h04, {24'h0, b} << (8 * (s % 4)), r);
	endtask

	// one processor access; gathers width, beats, clock toggles and latency
	task automatic acc(input logic [30:0] a, input logic word, input logic seq);
		logic c;
		lat = 0;
		beats = 0;
		tog = 0;
		last_a = 'x;
		a25 = 1'b0;
		c = eclk;
		@(posedge i_clk);
		acc_addr <= a;
		acc_word <= word;
		acc_seq <= seq;
		acc_req <= 1'b1;
		do
		begin
			@(posedge i_clk);
			lat++;
			if (csn !== 8'hff)
			begin
				if (csn !== ~(8'h01 << a[30:28]))
					cs_bad++; // wrong or extra select low
				w_seen = ewidth;
				if (eaddr !== last_a)
					beats++;
				last_a = eaddr;
				a25 = a25 | eaddr[25];
			end
			if (eclk !== c)
				tog++;
			c = eclk;
		end
		while (done !== 1'b1 && lat < 400);
		acc_req <= 1'b0;
		if (lat >= 400)
		begin
			n_errors++;
			finish_test();
		end
	endtask

	////////////////////////////////////////////////////////////////
	task automatic t_regs;
		logic [31:0] r;
		wb(1'b0, 8'h00, 32'h0, r); chk("cfg low reset", 32'h0, r);
		wb(1'b0, 8'h04, 32'h0, r); chk("cfg high reset", 32'h0, r);
		wb(1'b1, 8'h00, 32'ha5c3_5a3c, r);
		wb(1'b1, 8'h04, 32'h1234_5678, r);
		wb(1'b0, 8'h00, 32'h0, r); chk("cfg low", 32'ha5c3_5a3c, r);
		wb(1'b0, 8'h04, 32'h0, r); chk("cfg high", 32'h1234_5678, r);
		wb(1'b0, 8'h0c, 32'h0, r); chk("unmapped", 32'h0, r);
		wb(1'b1, 8'h04, 32'h0, r);
	endtask

	// every width code on select 1 with a26 high, so pcmcia shows as 16-bit
	task automatic t_width(input int f);
		for (int c = 0; c < 4; c++)
		begin
			setcfg(1, 8'h3c | 8'(c));
			acc({3'h1, 28'h400_0000}, 1'b0, 1'b0);
			chk("width", tbl[f][c], w_seen);
		end
	endtask

	// pcmcia areas on select 6: width, beats per word, io addressing
	task automatic t_pcm;
		for (int k = 0; k < 4; k++)
		begin
			setcfg(6, 8'h3f);
			acc({3'h6, 2'(k), 1'b1, 25'h0}, 1'b1, 1'b0);
			chk("pcm width", k[0] ? 2'h1 : 2'h2, w_seen);
			chk("beats", (k == 3) ? 1 : (k[0] ? 2 : 4), beats);
			if (k == 3)
			begin
				chk("io bit 25", 1'b0, a25);
				chk("io bit 1", 1'b1, last_a[1]);
			end
		end
	endtask

	// random wait codes on select 0, clock output left off
	task automatic t_wait;
		int lt [4];
		for (int c = 0; c < 4; c++)
		begin
			setcfg(0, 8'(c << 2));
			acc({3'h0, 28'h10}, 1'b1, 1'b0);
			lt[c] = lat;
			chk("clock idle", 0, tog);
		end
		for (int c = 0; c < 4; c++)
			chk("random waits", 3 - c, lt[c] - lt[3]);
		chk("read data", {4{8'h10}}, ardata);
		stall <= 4'h4;
		acc({3'h0, 28'h10}, 1'b1, 1'b0);
		stall <= 4'h0;
		chk("stretch", 1'b1, lat >= lt[3] + 3);
	endtask

	// page bursts on select 5: three page words then random again
	task automatic t_page;
		int r;
		setcfg(5, 8'hfc);
		acc({3'h5, 28'h0}, 1'b1, 1'b0);
		r = lat;
		chk("clock runs", 1'b1, tog > 0);
		for (int k = 1; k < 5; k++)
		begin
			acc({3'h5, 28'(k * 4)}, 1'b1, 1'b1);
			chk("page latency", (k < 4) ? r - 1 : r, lat);
			chk("clock runs", 1'b1, tog > 0);
		end
	endtask

	task automatic t_boot;
		logic [31:0] r;
		@(posedge i_clk);
		por <= 1'b1;
		pe0 <= 1'b1;
		repeat (6) @(posedge i_clk);
		por <= 1'b0;
		wb(1'b0, 8'h08, 32'h0, r); chk("boot flag", 1'b1, r[0]);
		t_width(1);
	endtask

	////////////////////////////////////////////////////////////////
	initial
	begin
		#1000000;
		n_errors++;
		finish_test();
	end

	initial
	begin
		logic [31:0] r;
		repeat (20) @(posedge i_clk);
		rst_n <= 1'b1;
		por <= 1'b0;
		wb(1'b0, 8'h08, 32'h0, r); chk("boot flag", 1'b0, r[0]);
		t_regs();
		t_width(0);
		t_pcm();
		t_wait();
		t_page();
		t_boot();
		chk("select", 0, cs_bad);
		finish_test();
	end
endmodule
`default_nettype wire
